// file: rtl/blu_unit.sv
`include "blu_defines.svh"
`default_nettype none

// Function
// - Double FP ops: sixteen functions, 64 bits
// - Single FP ops: same function, 32 bits
// - Zero and one fill codes ignore sources
// - Copy and complement of either source
// - OR, AND, XOR and negated forms
// - Mixed negation forms, both orientations
// - Single code is double code plus one
// - Second operand: register or sign-extended immediate
// - AND/OR/XOR codes; upper bit sets flags
// - ANDN/ORN invert second operand first
// - XNOR is XOR with negated result
// - Flag forms update both sets, clear v,c
// - Negative flags copy bits 31 and 63
// - Zero flags from low word, whole word
module blu_unit (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // Issue
    input wire logic issue_valid,
    input wire logic [31:0] instr,
    input wire logic fpu_enable,
    // Integer register operands
    input wire logic [63:0] int_rs1_data,
    input wire logic [63:0] int_rs2_data,
    // Floating-point register operands (single forms use bits 31:0)
    input wire logic [63:0] fp_rs1_data,
    input wire logic [63:0] fp_rs2_data,
    // Integer result
    output logic int_wr_en,
    output logic [4:0] int_wr_addr,
    output logic [63:0] int_wr_data,
    // Floating-point result
    output logic fp_wr_en,
    output logic fp_wr_single,
    output logic [4:0] fp_wr_addr,
    output logic [63:0] fp_wr_data,
    // Condition codes {n,z,v,c}
    output logic [3:0] icc,
    output logic [3:0] xcc,
    // Exceptions
    output logic float_unit_off_trap,
    output logic illegal_op
);

    ////////////////////////////////////////////////////////////////////////
    // Field extraction

    // Fields are cut unconditionally; the class decode below decides
    // whether any of them carries meaning for the word at hand.
    wire logic [1:0] op_field = instr[`BLU_OP_HI:`BLU_OP_LO];
    wire logic [5:0] primary_function_code = instr[`BLU_P3_HI:`BLU_P3_LO];
    wire logic [8:0] opf = instr[`BLU_OPF_HI:`BLU_OPF_LO];
    wire logic [4:0] rd_addr = instr[`BLU_RD_HI:`BLU_RD_LO];
    wire logic i_bit = instr[`BLU_IBIT];
    wire logic [12:0] signed_short_immediate = instr[`BLU_IMM_HI:`BLU_IMM_LO];

    // Integer class: codes 1 to 7 except 4, with or without the flag bit;
    // anything with code bit 3 or bit 5 set is outside it; of those only 0x36 (float logical) is executed here.
    function automatic blu_pkg::blu_kind_t kind_of(input logic [1:0] op,
                                                    input logic [5:0] p3,
                                                    input logic [8:0] f);
        blu_pkg::blu_kind_t k;
        k = blu_pkg::BLU_K_NONE;
        if (op == `BLU_OP_ARITH)
        begin
            if (p3 == `BLU_P3_FLOGIC && f[8:5] == 4'(`BLU_OPF_BASE >> 5))
                k = blu_pkg::BLU_K_FP;
            else if (p3[5] == 1'b0 && p3[3] == 1'b0 && p3[2:0] != 3'h0
                     && p3[2:0] != 3'h4)
                k = blu_pkg::BLU_K_INT;
        end
        return k;
    endfunction

    wire blu_pkg::blu_kind_t kind = kind_of(op_field, primary_function_code, opf);
    wire logic is_fp = issue_valid && kind == blu_pkg::BLU_K_FP;
    wire logic is_int = issue_valid && kind == blu_pkg::BLU_K_INT;
    wire logic set_cc = primary_function_code[`BLU_P3_CC_BIT];

    ////////////////////////////////////////////////////////////////////////
    // Floating-point logical: opf[4:1] is itself a truth table, indexed {b,a}

    // The evaluator indexes its table {a,b}, so the two middle bits swap.
    // Every code is listed rather than bit-swapped, so each encoding can
    // be read off against the opcode list directly.
    // The lsb only picks the width; it is cleared before the lookup.
    function automatic logic [3:0] fp_table(input logic [8:0] f);
        logic [8:0] d;
        logic [3:0] t;
        d = {f[8:1], 1'b0};
        unique case (d)
            `BLU_OPF_ZERO: t = 4'h0;
            `BLU_OPF_ONE: t = 4'hf;
            `BLU_OPF_SRC1: t = 4'hc;
            `BLU_OPF_NOT1: t = 4'h3;
            `BLU_OPF_SRC2: t = 4'ha;
            `BLU_OPF_NOT2: t = 4'h5;
            `BLU_OPF_OR: t = 4'he;
            `BLU_OPF_AND: t = 4'h8;
            `BLU_OPF_XOR: t = 4'h6;
            `BLU_OPF_NOR: t = 4'h1;
            `BLU_OPF_NAND: t = 4'h7;
            `BLU_OPF_XNOR: t = 4'h9;
            `BLU_OPF_ORNOT1: t = 4'hb;
            `BLU_OPF_ORNOT2: t = 4'hd;
            `BLU_OPF_ANDNOT1: t = 4'h2;
            `BLU_OPF_ANDNOT2: t = 4'h4;
            default: t = 4'h0;
        endcase
        return t;
    endfunction

    wire logic fp_single = opf[0];
    wire logic [3:0] fp_tt = fp_table(opf);
    wire logic [63:0] fp_y;

    // One 64-bit evaluator serves both widths; single forms keep the low word
    blu_fn16 #(.W(64)) u_fp_fn (
        .tt(fp_tt),
        .a(fp_rs1_data),
        .b(fp_rs2_data),
        .y(fp_y)
    );

    // Single forms zero the upper word so no stale half leaks out
    wire logic [63:0] fp_res = fp_single ? {32'h0, fp_y[31:0]} : fp_y;

    ////////////////////////////////////////////////////////////////////////
    // Integer logical

    // ANDN, ORN and XNOR share one inverter on the second operand;
    // XNOR then falls out of the XOR path with no extra gate.
    wire logic [63:0] opnd2 = i_bit ? {{51{signed_short_immediate[12]}},
                                       signed_short_immediate}
                                    : int_rs2_data;
    wire logic [2:0] ifn = primary_function_code[2:0];
    wire logic [63:0] opnd2_n = ifn[2] ? ~opnd2 : opnd2;
    wire logic [63:0] int_and = int_rs1_data & opnd2_n;
    wire logic [63:0] int_or = int_rs1_data | opnd2_n;
    wire logic [63:0] int_xor = int_rs1_data ^ opnd2_n;
    wire logic [63:0] int_res = (ifn[1:0] == 2'h1) ? int_and :
                                (ifn[1:0] == 2'h2) ? int_or : int_xor;

    wire logic [3:0] icc_new = {int_res[31], int_res[31:0] == 32'h0,
                                2'b00};
    wire logic [3:0] xcc_new = {int_res[63], int_res == 64'h0,
                                2'b00};

    wire logic fp_trap = is_fp && !fpu_enable;
    // A word of neither class is flagged rather than dropped silently;
    // nothing is written for it.
    wire logic bad_op = issue_valid && kind == blu_pkg::BLU_K_NONE;

    ////////////////////////////////////////////////////////////////////////
    // Result stage

    // Enables and traps pulse one cycle per issue; data and address follow
    // the inputs every cycle, so a consumer must qualify them with the enable.
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            int_wr_en <= 1'b0;
            fp_wr_en <= 1'b0;
            float_unit_off_trap <= 1'b0;
            illegal_op <= 1'b0;
        end
        else
        begin
            int_wr_en <= is_int;
            fp_wr_en <= is_fp && fpu_enable;
            float_unit_off_trap <= fp_trap;
            illegal_op <= bad_op;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            int_wr_addr <= 5'h0;
            int_wr_data <= 64'h0;
            fp_wr_addr <= 5'h0;
            fp_wr_data <= 64'h0;
            fp_wr_single <= 1'b0;
        end
        else
        begin
            int_wr_addr <= rd_addr;
            int_wr_data <= int_res;
            fp_wr_addr <= rd_addr;
            fp_wr_data <= fp_res;
            fp_wr_single <= fp_single;
        end
    end

    // Flags change only on a flag-setting integer op
    // A disabled float op or an illegal word never touches them
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            icc <= `BLU_CC_RST;
            xcc <= `BLU_CC_RST;
        end
        else if (is_int && set_cc)
        begin
            icc <= icc_new;
            xcc <= xcc_new;
        end
    end

endmodule
`default_nettype wire

// file: rtl/blu_defines.svh
`ifndef BLU_DEFINES_SVH
`define BLU_DEFINES_SVH

// Instruction fields
`define BLU_OP_HI 31
`define BLU_OP_LO 30
`define BLU_RD_HI 29
`define BLU_RD_LO 25
`define BLU_P3_HI 24
`define BLU_P3_LO 19
`define BLU_RS1_HI 18
`define BLU_RS1_LO 14
`define BLU_IBIT 13
`define BLU_OPF_HI 13
`define BLU_OPF_LO 5
`define BLU_RS2_HI 4
`define BLU_RS2_LO 0
`define BLU_IMM_HI 12
`define BLU_IMM_LO 0

// Major opcode and primary function codes
`define BLU_OP_ARITH 2'h2
`define BLU_P3_FLOGIC 6'h36
`define BLU_P3_AND 6'h01
`define BLU_P3_OR 6'h02
`define BLU_P3_XOR 6'h03
`define BLU_P3_ANDN 6'h05
`define BLU_P3_ORN 6'h06
`define BLU_P3_XNOR 6'h07
`define BLU_P3_CC_BIT 4

// Floating-point logical opf codes (double forms; single = lsb set)
`define BLU_OPF_BASE 9'h060
`define BLU_OPF_ZERO 9'h060
`define BLU_OPF_NOR 9'h062
`define BLU_OPF_ANDNOT2 9'h064
`define BLU_OPF_NOT2 9'h066
`define BLU_OPF_ANDNOT1 9'h068
`define BLU_OPF_NOT1 9'h06a
`define BLU_OPF_XOR 9'h06c
`define BLU_OPF_NAND 9'h06e
`define BLU_OPF_AND 9'h070
`define BLU_OPF_XNOR 9'h072
`define BLU_OPF_SRC1 9'h074
`define BLU_OPF_ORNOT2 9'h076
`define BLU_OPF_SRC2 9'h078
`define BLU_OPF_ORNOT1 9'h07a
`define BLU_OPF_OR 9'h07c
`define BLU_OPF_ONE 9'h07e

// Condition code layout {n,z,v,c}
`define BLU_CC_N 3
`define BLU_CC_Z 2
`define BLU_CC_V 1
`define BLU_CC_C 0
`define BLU_CC_RST 4'h0

`endif

// file: rtl/blu_pkg.sv
`default_nettype none
package blu_pkg;
    typedef enum logic [1:0] {
        BLU_K_NONE,
        BLU_K_INT,
        BLU_K_FP
    } blu_kind_t;
endpackage
`default_nettype wire

// file: rtl/blu_fn16.sv
`include "blu_defines.svh"
`default_nettype none

// One of sixteen two-input functions, selected by a truth table per bit
module blu_fn16 #(
    parameter int W = 64
) (
    // Function select: bit {a,b} of the table gives the output
    input wire logic [3:0] tt,
    // Operands
    input wire logic [W-1:0] a,
    input wire logic [W-1:0] b,
    // Result
    output logic [W-1:0] y
);
    genvar g;
    generate
        for (g = 0; g < W; g++)
        begin : g_bit
            assign y[g] = tt[{a[g], b[g]}];
        end
    endgenerate
endmodule
`default_nettype wire

// file: test/blu_chk_sva.sv
`default_nettype none
module blu_chk (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // Issue
    input wire logic issue_valid,
    input wire logic [31:0] instr,
    input wire logic fpu_enable,
    // Results
    input wire logic int_wr_en,
    input wire logic [63:0] int_wr_data,
    input wire logic fp_wr_en,
    input wire logic fp_wr_single,
    input wire logic [4:0] fp_wr_addr,
    input wire logic [63:0] fp_wr_data,
    input wire logic [3:0] icc,
    input wire logic [3:0] xcc,
    input wire logic float_unit_off_trap,
    input wire logic illegal_op
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    wire logic fp_op = issue_valid && instr[31:30] == 2'h2 && instr[24:19] == 6'h36
        && instr[13:10] == 4'h3;
    wire logic int_op = issue_valid && instr[31:30] == 2'h2 && !instr[24] && !instr[22]
        && instr[20:19] != 2'h0;
    wire logic cc_op = int_op && instr[23];
    chk_int_write: assert property (int_op |=> int_wr_en && !illegal_op
        && !float_unit_off_trap) else $error("integer op not written");
    chk_fp_write: assert property (fp_op && fpu_enable |=> fp_wr_en
        && fp_wr_addr == $past(instr[29:25]) && fp_wr_single == $past(instr[5]))
        else $error("fp op not written");
    chk_fp_off_trap: assert property (fp_op && !fpu_enable |=>
        float_unit_off_trap && !fp_wr_en) else $error("disabled fp op wrote");
    chk_fill_zero: assert property (fp_op && fpu_enable && instr[13:5] == 9'h060
        |=> fp_wr_data == 64'h0) else $error("zero fill wrong");
    chk_single_upper: assert property (fp_wr_en && fp_wr_single |->
        fp_wr_data[63:32] == 32'h0) else $error("single upper word set");
    chk_cc_vc_clear: assert property (cc_op |=> icc[1:0] == 2'h0
        && xcc[1:0] == 2'h0) else $error("v or c not cleared");
    chk_neg_flags: assert property (cc_op |=> icc[3] == int_wr_data[31]
        && xcc[3] == int_wr_data[63]) else $error("negative flag wrong");
    chk_zero_flags: assert property (cc_op |=>
        icc[2] == (int_wr_data[31:0] == 32'h0) && xcc[2] == (int_wr_data == 64'h0))
        else $error("zero flag wrong");
    chk_cc_hold: assert property (!cc_op |=> $stable(icc) && $stable(xcc))
        else $error("flags changed");
    chk_illegal_op: assert property (issue_valid && !fp_op && !int_op |=>
        illegal_op && !int_wr_en && !fp_wr_en) else $error("illegal op wrote");
    chk_idle_quiet: assert property (!issue_valid |=> !int_wr_en && !fp_wr_en
        && !float_unit_off_trap && !illegal_op) else $error("idle cycle raised an output");
endmodule
bind blu_unit blu_chk u_chk (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .issue_valid(issue_valid),
    .instr(instr),
    .fpu_enable(fpu_enable),
    .int_wr_en(int_wr_en),
    .int_wr_data(int_wr_data),
    .fp_wr_en(fp_wr_en),
    .fp_wr_single(fp_wr_single),
    .fp_wr_addr(fp_wr_addr),
    .fp_wr_data(fp_wr_data),
    .icc(icc),
    .xcc(xcc),
    .float_unit_off_trap(float_unit_off_trap),
    .illegal_op(illegal_op)
);
`default_nettype wire

// file: test/blu_unit_bench.sv
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_count++; \
    $display("Error %0t: mismatch", $time); end end
module blu_unit_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic issue_valid = 1'b0;
    logic fpu_enable = 1'b1;
    logic [31:0] instr = 32'h0;
    logic [63:0] int_rs1_data = 64'h0, int_rs2_data = 64'h0;
    logic [63:0] fp_rs1_data = 64'h0, fp_rs2_data = 64'h0;
    logic int_wr_en, fp_wr_en, fp_wr_single, float_unit_off_trap, illegal_op;
    logic [4:0] int_wr_addr, fp_wr_addr;
    logic [63:0] int_wr_data, fp_wr_data;
    logic [3:0] icc, xcc;
    logic [3:0] eicc = 4'h0, excc = 4'h0;
    int err_count = 0;
    int num_checks = 0;
    logic [2:0] lst [6] = '{3'h1, 3'h2, 3'h3, 3'h5, 3'h6, 3'h7};
    blu_unit DUT (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .issue_valid(issue_valid),
        .instr(instr),
        .fpu_enable(fpu_enable),
        .int_rs1_data(int_rs1_data),
        .int_rs2_data(int_rs2_data),
        .fp_rs1_data(fp_rs1_data),
        .fp_rs2_data(fp_rs2_data),
        .int_wr_en(int_wr_en),
        .int_wr_addr(int_wr_addr),
        .int_wr_data(int_wr_data),
        .fp_wr_en(fp_wr_en),
        .fp_wr_single(fp_wr_single),
        .fp_wr_addr(fp_wr_addr),
        .fp_wr_data(fp_wr_data),
        .icc(icc),
        .xcc(xcc),
        .float_unit_off_trap(float_unit_off_trap),
        .illegal_op(illegal_op)
    );
    ////////////////////////////////////////
    function automatic logic [63:0] fexp(logic [8:0] f, logic [63:0] a, logic [63:0] b);
        logic [63:0] y;
        for (int k = 0; k < 64; k++)
            y[k] = f[1 + {b[k], a[k]}];
        return f[0] ? {32'h0, y[31:0]} : y;
    endfunction
    function automatic logic [63:0] iexp(logic [31:0] w, logic [63:0] a, logic [63:0] r2);
        logic [63:0] b;
        b = w[13] ? {{51{w[12]}}, w[12:0]} : r2;
        case (w[21:19])
            3'h1: return a & b;
            3'h2: return a | b;
            3'h3: return a ^ b;
            3'h5: return a & ~b;
            3'h6: return a | ~b;
            default: return ~(a ^ b);
        endcase
    endfunction
    // Equal operands now and then, so zero results reach the flags
    task automatic run_op(input logic [31:0] w, input logic fen, input logic vld);
        logic is_fp, is_int;
        logic [63:0] r, ef;
        is_fp = vld && w[31:30] == 2'h2 && w[24:19] == 6'h36 && w[13:10] == 4'h3;
        is_int = vld && w[31:30] == 2'h2 && !w[24] && !w[22] && w[20:19] != 2'h0;
        instr = w;
        fpu_enable = fen;
        issue_valid = vld;
        int_rs1_data = {$urandom, $urandom};
        int_rs2_data = ($urandom % 4 == 0) ? int_rs1_data : {$urandom, $urandom};
        fp_rs1_data = {$urandom, $urandom};
        fp_rs2_data = {$urandom, $urandom};
        r = iexp(w, int_rs1_data, int_rs2_data);
        ef = fexp(w[13:5], fp_rs1_data, fp_rs2_data);
        if (is_int && w[23])
        begin
            eicc = {r[31], r[31:0] == 32'h0, 2'h0};
            excc = {r[63], r == 64'h0, 2'h0};
        end
        @(negedge ref_clk);
        `CHK(int_wr_en, is_int)
        `CHK(fp_wr_en, is_fp && fen)
        `CHK(float_unit_off_trap, is_fp && !fen)
        `CHK(illegal_op, vld && !is_int && !is_fp)
        `CHK(icc, eicc)
        `CHK(xcc, excc)
        if (is_int) `CHK({int_wr_addr, int_wr_data}, {w[29:25], r})
        if (is_fp && fen) `CHK({fp_wr_single, fp_wr_addr, fp_wr_data}, {w[5], w[29:25], ef})
    endtask
    task automatic print_verdict;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////
    initial
    begin
        forever #5 ref_clk = ~ref_clk;
    end
    initial
    begin
        logic [31:0] w;
        void'($urandom(32'h970e));
        repeat (10) @(negedge ref_clk);
        rst_b = 1'b1;
        for (int k = 0; k < 34; k++)
            run_op({2'h2, 5'h3, 6'h36, 5'h1, 4'h3, k[4:0], 5'h2}, k < 32, 1'b1);
        $display("fp codes done");
        for (int k = 0; k < 24; k++)
            run_op({2'h2, 5'h4, 1'b0, 1'(k / 6 % 2), 1'b0, lst[k % 6], 5'h5, 1'(k / 12),
                13'h1abc}, 1'b1, 1'b1);
        run_op({2'h2, 5'h0, 6'h04, 19'h0}, 1'b1, 1'b1);
        $display("int codes done");
        repeat (300)
        begin
            w = $urandom;
            case ($urandom % 3)
                0: w = {2'h2, w[29:25], 1'b0, w[23], 1'b0, lst[$urandom % 6], w[18:0]};
                1: w = {2'h2, w[29:25], 6'h36, w[18:14], 4'h3, w[9:0]};
                default: ;
            endcase
            run_op(w, $urandom % 8 != 0, $urandom % 6 != 0);
        end
        $display("random done");
        // Reset in mid-run, with a word still issued: all clears at once
        rst_b = 1'b0;
        @(negedge ref_clk);
        `CHK({int_wr_en, fp_wr_en, float_unit_off_trap, illegal_op, icc, xcc}, 12'h0)
        `CHK({int_wr_addr, int_wr_data, fp_wr_single, fp_wr_addr, fp_wr_data}, 139'h0)
        rst_b = 1'b1;
        eicc = 4'h0;
        excc = 4'h0;
        for (int k = 0; k < 12; k++)
            run_op({2'h2, 5'h7, 3'h2, lst[k % 6], 5'h1, 1'(k % 2), 13'(k * 523)}, 1'b1,
                1'b1);
        $display("reset done");
        print_verdict();
    end
endmodule
`default_nettype wire
